// ### core/lpm_defines.svh
// named constants for the low-power mode controller and vector map
`ifndef LPM_DEFINES_SVH
`define LPM_DEFINES_SVH

// vector map, each entry is the address of the high byte
`define LPM_VEC_BASE 16'hFFDC
`define LPM_VEC_SWI 16'hFFFC
`define LPM_VEC_IRQ 16'hFFFA
`define LPM_VEC_RESET 16'hFFFE
`define LPM_VEC_LO_BIT 16'h0001

// wake source indices, priority rises with index
`define LPM_NUM_SRC 16
`define LPM_IDX_TIMEBASE 0
`define LPM_IDX_ADC 1
`define LPM_IDX_KBD 2
`define LPM_IDX_RSVD 9
`define LPM_IDX_IRQ 15

// oscillator stabilization delay
`define LPM_OSC_STAB_NS 32'h0001_4000
`define LPM_CLK_PERIOD_NS 32'h0000_0014
`define LPM_STAB_CNT_W 16

// peripheral indications
`define LPM_NUM_PERIPH 8
`define LPM_WAIT_KEEP 8'hFF
`define LPM_STOP_KEEP 8'h00

// reset values
`define LPM_IMASK_RST 1'b1
`define LPM_CLK_SEL_RST 1'b0
`define LPM_PLL_ON_RST 1'b0

`endif

// ### core/lpm_pkg.sv
// types shared by the low-power mode controller
`include "lpm_defines.svh"

package lpm_pkg;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_WAIT,
    ST_STOP,
    ST_STAB
  } lpm_state_e;

  typedef struct packed {
    lpm_state_e state;
    logic imask;
    logic clk_sel;
    logic pll_on;
    logic brk_flag;
    logic [15:0] vec;
    logic restart;
    logic adc_abort;
    logic [`LPM_STAB_CNT_W-1:0] cnt;
  } lpm_state_s;

endpackage : lpm_pkg

// ### core/vector_select.sv
// priority encoder from wake requests to a vector address
`timescale 1ns/1ps
`include "lpm_defines.svh"

module vector_select #(
  parameter int NUM_SRC = `LPM_NUM_SRC
) (
  input wire logic [NUM_SRC-1:0] req_i,
  input wire logic reset_i,
  input wire logic swi_i,
  output logic [15:0] addr_o,
  output logic valid_o
);

  // highest set index wins, the reserved slot never takes part
  function automatic logic [4:0] top_index(input logic [NUM_SRC-1:0] r);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (r[i] && i != `LPM_IDX_RSVD) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : top_index

  logic [NUM_SRC-1:0] live;
  logic [4:0] idx;

  // reserved pair is left unused
  always_comb begin
    live = req_i;
    live[`LPM_IDX_RSVD] = 1'b0;
    idx = top_index(live);
  end

  // reset above software interrupt above every peripheral
  always_comb begin
    if (reset_i) begin
      addr_o = `LPM_VEC_RESET;
    end else if (swi_i) begin
      addr_o = `LPM_VEC_SWI;
    end else begin
      // two bytes per vector from the timebase upward
      addr_o = `LPM_VEC_BASE + 16'({idx, 1'b0});
    end
    valid_o = reset_i | swi_i | (|live);
  end

endmodule : vector_select

// ### core/low_power_mode_control.sv
// wait/stop low-power controller with clock gating and wake vectors
`timescale 1ns/1ps
`include "lpm_defines.svh"

module low_power_mode_control
  import lpm_pkg::*;
#(
  parameter int NUM_SRC = `LPM_NUM_SRC,
  parameter int NUM_PERIPH = `LPM_NUM_PERIPH,
  parameter logic [NUM_PERIPH-1:0] WAIT_KEEP = `LPM_WAIT_KEEP,
  parameter logic [NUM_PERIPH-1:0] STOP_KEEP = `LPM_STOP_KEEP,
  parameter int OSC_STAB_CYCLES =
    (`LPM_OSC_STAB_NS + `LPM_CLK_PERIOD_NS - 1) / `LPM_CLK_PERIOD_NS
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // cpu side
  input wire logic wait_exec_i,
  input wire logic stop_exec_i,
  input wire logic cpu_sei_i,
  input wire logic cpu_cli_i,
  // configuration
  input wire logic osc_run_in_stop_en_i,
  input wire logic brk_en_i,
  input wire logic [4:0] converter_channel_select_i,
  // pll control register write port
  input wire logic pll_ctl_wr_i,
  input wire logic clock_source_select_wdata_i,
  input wire logic pll_power_enable_wdata_i,
  // wake sources and the break flag clear
  input wire logic [NUM_SRC-1:0] irq_req_i,
  input wire logic [NUM_SRC-1:0] irq_en_i,
  input wire logic break_irq_i,
  input wire logic reset_req_i,
  input wire logic brk_flag_clr_i,
  // clock controls
  output logic cpu_clk_en_o,
  output logic bus_clk_en_o,
  output logic osc_en_o,
  output logic pll_en_o,
  output logic crystal_clock_out_en_o,
  output logic system_clock_out_en_o,
  output logic clock_gen_interrupt_en_o,
  // status
  output logic imask_o,
  output logic clock_source_select_o,
  output logic pll_power_enable_o,
  output logic break_during_wait_flag_o,
  output logic in_wait_o,
  output logic in_stop_o,
  // peripheral controls
  output logic adc_active_o,
  output logic adc_abort_o,
  output logic brk_active_o,
  output logic [NUM_PERIPH-1:0] wait_active_o,
  output logic [NUM_PERIPH-1:0] stop_active_o,
  // wake result
  output logic cpu_restart_o,
  output logic [15:0] vector_hi_addr_o,
  output logic [15:0] vector_lo_addr_o
);

  localparam logic [`LPM_STAB_CNT_W-1:0] STAB_LAST =
    `LPM_STAB_CNT_W'(OSC_STAB_CYCLES - 1);

  localparam lpm_state_s RESET_S = '{
    state: ST_RUN,
    imask: `LPM_IMASK_RST,
    clk_sel: `LPM_CLK_SEL_RST,
    pll_on: `LPM_PLL_ON_RST,
    brk_flag: 1'b0,
    vec: `LPM_VEC_RESET,
    restart: 1'b0,
    adc_abort: 1'b0,
    cnt: '0
  };

  lpm_state_s s_q;
  lpm_state_s s_d;

  logic adc_pd;
  logic [NUM_SRC-1:0] wake_src;
  logic [NUM_SRC-1:0] ext_mask;
  logic [NUM_SRC-1:0] sel_req;
  logic [15:0] sel_addr;
  logic sel_valid;
  logic ext_wake;

  // converter powered down by software ahead of wait cannot wake
  assign adc_pd = &converter_channel_select_i;

  // enabled requests only, converter dropped when powered down
  always_comb begin
    wake_src = irq_req_i & irq_en_i;
    if (adc_pd) begin
      wake_src[`LPM_IDX_ADC] = 1'b0;
    end
    ext_mask = '0;
    ext_mask[`LPM_IDX_IRQ] = 1'b1;
    ext_mask[`LPM_IDX_KBD] = 1'b1;
  end

  // in stop only the pin and keyboard interrupts still have a clock
  assign sel_req = (s_q.state == ST_STOP) ? (wake_src & ext_mask) : wake_src;
  assign ext_wake = |(wake_src & ext_mask);

  vector_select #(
    .NUM_SRC(NUM_SRC)
  ) u_vector_select (
    .req_i(sel_req),
    .reset_i(reset_req_i),
    .swi_i(break_irq_i),
    .addr_o(sel_addr),
    .valid_o(sel_valid)
  );

  // next state of the whole controller
  always_comb begin
    s_d = s_q;
    s_d.restart = 1'b0;
    s_d.adc_abort = 1'b0;
    // software owns the pll control bits while running
    if (pll_ctl_wr_i) begin
      s_d.clk_sel = clock_source_select_wdata_i;
      s_d.pll_on = pll_power_enable_wdata_i;
    end
    // clear first so a break in the same cycle still sets the flag
    if (brk_flag_clr_i) begin
      s_d.brk_flag = 1'b0;
    end
    case (s_q.state)
      ST_RUN: begin
        if (cpu_sei_i) begin
          s_d.imask = 1'b1;
        end else if (cpu_cli_i) begin
          s_d.imask = 1'b0;
        end
        // only the instruction strobes lead into a low-power mode
        if (wait_exec_i) begin
          s_d.state = ST_WAIT;
          s_d.imask = 1'b0;
        end else if (stop_exec_i) begin
          s_d.state = ST_STOP;
          s_d.imask = 1'b0;
          s_d.adc_abort = 1'b1;
          // fall back to the crystal clock, beats a same-cycle write
          s_d.clk_sel = 1'b0;
        end
      end
      ST_WAIT: begin
        if (reset_req_i) begin
          s_d.state = ST_RUN;
          s_d.imask = 1'b1;
          s_d.restart = 1'b1;
          s_d.vec = sel_addr;
        end else if (break_irq_i) begin
          s_d.state = ST_RUN;
          s_d.brk_flag = 1'b1;
          s_d.restart = 1'b1;
          s_d.vec = sel_addr;
        end else if (sel_valid) begin
          s_d.state = ST_RUN;
          s_d.restart = 1'b1;
          s_d.vec = sel_addr;
        end
      end
      ST_STOP: begin
        s_d.cnt = '0;
        if (reset_req_i) begin
          s_d.state = ST_STAB;
          s_d.imask = 1'b1;
          s_d.vec = sel_addr;
        end else if (break_irq_i) begin
          s_d.state = ST_STAB;
          s_d.brk_flag = 1'b1;
          s_d.vec = sel_addr;
        end else if (ext_wake) begin
          s_d.state = ST_STAB;
          s_d.vec = sel_addr;
        end
      end
      ST_STAB: begin
        // oscillator restart, cpu stays off until the count runs out
        if (s_q.cnt == STAB_LAST) begin
          s_d.state = ST_RUN;
          s_d.restart = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 1'b1;
        end
      end
      default: begin
        s_d = RESET_S;
      end
    endcase
  end

  // the single state register
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= RESET_S;
    end else begin
      s_q <= s_d;
    end
  end

  // clock gating; the bus keeps running through stabilization
  always_comb begin
    cpu_clk_en_o = (s_q.state == ST_RUN);
    bus_clk_en_o = (s_q.state != ST_STOP) || osc_run_in_stop_en_i;
    osc_en_o = (s_q.state != ST_STOP) || osc_run_in_stop_en_i;
    pll_en_o = s_q.pll_on && (s_q.state != ST_STOP);
    crystal_clock_out_en_o = osc_en_o;
    system_clock_out_en_o = osc_en_o;
    // pll is off in stop either way, so its interrupt has no source
    clock_gen_interrupt_en_o = (s_q.state != ST_STOP);
  end

  // unit indications taken from the mode state
  always_comb begin
    in_wait_o = (s_q.state == ST_WAIT);
    in_stop_o = (s_q.state == ST_STOP);
    adc_active_o = (s_q.state == ST_RUN) || (s_q.state == ST_WAIT);
    brk_active_o = brk_en_i && (s_q.state != ST_STOP);
    wait_active_o = {NUM_PERIPH{in_wait_o}} & WAIT_KEEP;
    stop_active_o = {NUM_PERIPH{in_stop_o}} & STOP_KEEP;
  end

  assign imask_o = s_q.imask;
  assign clock_source_select_o = s_q.clk_sel;
  assign pll_power_enable_o = s_q.pll_on;
  assign break_during_wait_flag_o = s_q.brk_flag;
  assign adc_abort_o = s_q.adc_abort;
  assign cpu_restart_o = s_q.restart;
  assign vector_hi_addr_o = s_q.vec;
  assign vector_lo_addr_o = s_q.vec | `LPM_VEC_LO_BIT;

  // ---- assertions
  property p_wait_clocks;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    in_wait_o |-> !cpu_clk_en_o && bus_clk_en_o && osc_en_o;
  endproperty
  a_wait_clocks: assert property (p_wait_clocks)
    else $error("wait mode clock gating wrong");

  property p_stop_bus;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    in_stop_o && !osc_run_in_stop_en_i |-> !bus_clk_en_o && !cpu_clk_en_o;
  endproperty
  a_stop_bus: assert property (p_stop_bus)
    else $error("bus clock running in stop");

  property p_wait_entry;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    cpu_clk_en_o && wait_exec_i |=> in_wait_o && !imask_o;
  endproperty
  a_wait_entry: assert property (p_wait_entry)
    else $error("wait entry did not clear mask");

  property p_reset_exit;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    in_wait_o && reset_req_i |=>
      imask_o && cpu_restart_o && vector_hi_addr_o == `LPM_VEC_RESET;
  endproperty
  a_reset_exit: assert property (p_reset_exit)
    else $error("reset exit from wait wrong");

  property p_stop_entry;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    cpu_clk_en_o && stop_exec_i && !wait_exec_i |=>
      in_stop_o && !clock_source_select_o && adc_abort_o && !adc_active_o;
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop entry effects missing");

  property p_stab_len;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(cpu_clk_en_o) && $past(s_q.state) == ST_STAB |->
      $past(s_q.cnt) == STAB_LAST;
  endproperty
  a_stab_len: assert property (p_stab_len)
    else $error("cpu clock restarted early");

  property p_stop_cgm;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    in_stop_o && !osc_run_in_stop_en_i |->
      !crystal_clock_out_en_o && !system_clock_out_en_o &&
      !clock_gen_interrupt_en_o && !pll_en_o;
  endproperty
  a_stop_cgm: assert property (p_stop_cgm)
    else $error("clock generator outputs not held low");

  property p_keep_osc;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    in_stop_o && osc_run_in_stop_en_i |-> osc_en_o && !pll_en_o;
  endproperty
  a_keep_osc: assert property (p_keep_osc)
    else $error("kept oscillator or pll wrong in stop");

  property p_brk_stop;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    in_stop_o && break_irq_i && !reset_req_i |=>
      break_during_wait_flag_o && s_q.state == ST_STAB;
  endproperty
  a_brk_stop: assert property (p_brk_stop)
    else $error("break did not end stop");

  property p_irq_vec;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    in_wait_o && !reset_req_i && !break_irq_i &&
      irq_req_i[`LPM_IDX_IRQ] && irq_en_i[`LPM_IDX_IRQ] |=>
      cpu_restart_o && vector_hi_addr_o == `LPM_VEC_IRQ;
  endproperty
  a_irq_vec: assert property (p_irq_vec)
    else $error("pin interrupt vector wrong");

endmodule : low_power_mode_control

// ### verif/wake_src_model.sv
// wake request sources standing in for the peripherals
`timescale 1ns/1ps
module wake_src_model (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic cpu_restart_i,
  output logic [15:0] irq_req_o
);
  logic [15:0] req_mask = 16'h0000;
  int req_seq = 0;
  int seen_seq;

  // a request is a level; dly lets a source answer slowly
  // the task only posts the mask, so the request pins keep a single driver
  task automatic raise(input logic [15:0] mask, input int dly);
    repeat (dly) @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    req_mask <= mask;
    req_seq <= req_seq + 1;
  endtask : raise

  // a posted mask reaches the pins one edge later, like a registered source
  // a serviced wake acknowledges every pending source
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_req_o <= 16'h0000;
      seen_seq <= 0;
    end else if (seen_seq != req_seq) begin
      irq_req_o <= req_mask;
      seen_seq <= req_seq;
    end else if (cpu_restart_i) begin
      irq_req_o <= 16'h0000;
    end
  end
endmodule : wake_src_model

// ### verif/low_power_mode_control_tb_top.sv
// self-checking bench for the low-power mode controller
`timescale 1ns/1ps
module low_power_mode_control_tb_top;
  localparam int STAB = 4;
  logic clk_sys_i, resetn_i, wait_exec_i, stop_exec_i, pll_ctl_wr_i;
  logic osc_run_in_stop_en_i, brk_en_i, break_irq_i, reset_req_i;
  logic clock_source_select_wdata_i, pll_power_enable_wdata_i;
  logic [4:0] converter_channel_select_i;
  logic [15:0] irq_req_i, irq_en_i, vector_hi_addr_o, vector_lo_addr_o, v;
  logic cpu_clk_en_o, bus_clk_en_o, osc_en_o, pll_en_o, crystal_clock_out_en_o;
  logic system_clock_out_en_o, clock_gen_interrupt_en_o, imask_o, clock_source_select_o;
  logic pll_power_enable_o, break_during_wait_flag_o, in_wait_o, in_stop_o;
  logic adc_active_o, adc_abort_o, brk_active_o, cpu_restart_o;
  logic cpu_sei_i, cpu_cli_i, brk_flag_clr_i;
  logic [7:0] wait_active_o, stop_active_o;
  logic [8:0] st;
  logic [31:0] rnd = 32'h0000_dc7f;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int checked = 0;
  int n;

  low_power_mode_control #(.OSC_STAB_CYCLES(STAB)) DUT (
    .clk_sys_i, .resetn_i, .wait_exec_i, .stop_exec_i, .cpu_sei_i, .cpu_cli_i,
    .osc_run_in_stop_en_i, .brk_en_i, .converter_channel_select_i, .pll_ctl_wr_i,
    .clock_source_select_wdata_i, .pll_power_enable_wdata_i, .irq_req_i, .irq_en_i,
    .break_irq_i, .reset_req_i, .brk_flag_clr_i, .cpu_clk_en_o, .bus_clk_en_o,
    .osc_en_o, .pll_en_o, .crystal_clock_out_en_o, .system_clock_out_en_o,
    .clock_gen_interrupt_en_o, .imask_o, .clock_source_select_o, .pll_power_enable_o,
    .break_during_wait_flag_o, .in_wait_o, .in_stop_o, .adc_active_o, .adc_abort_o,
    .brk_active_o, .wait_active_o, .stop_active_o, .cpu_restart_o, .vector_hi_addr_o,
    .vector_lo_addr_o);

  wake_src_model u_src (.clk_sys_i, .resetn_i, .cpu_restart_i(cpu_restart_o),
    .irq_req_o(irq_req_i));

  // clock enables plus converter and break activity packed so one compare covers a whole mode
  assign st = {cpu_clk_en_o, bus_clk_en_o, osc_en_o, crystal_clock_out_en_o,
    system_clock_out_en_o, clock_gen_interrupt_en_o, pll_en_o, adc_active_o, brk_active_o};

  // 50 MHz system clock
  always #10 clk_sys_i = ~clk_sys_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic close_out();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one-cycle instruction strobe, sampled once its effect has landed
  task automatic strobe(input logic is_stop);
    @(posedge clk_sys_i);
    if (is_stop) begin
      stop_exec_i <= 1'b1;
    end else begin
      wait_exec_i <= 1'b1;
    end
    @(posedge clk_sys_i);
    wait_exec_i <= 1'b0;
    stop_exec_i <= 1'b0;
    #1;
  endtask : strobe

  // one-cycle pulse on the mask set, mask clear and flag clear inputs
  task automatic ctl_pulse(input logic [2:0] p);
    @(posedge clk_sys_i);
    {cpu_sei_i, cpu_cli_i, brk_flag_clr_i} <= p;
    @(posedge clk_sys_i);
    {cpu_sei_i, cpu_cli_i, brk_flag_clr_i} <= 3'h0;
    #1;
  endtask : ctl_pulse

  // counts edges from the request edge to the restart pulse, bounded
  task automatic wait_restart(output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      cnt++;
    end while (cpu_restart_o !== 1'b1 && cnt < 50);
    if (cnt >= 50) begin
      num_errors++;
      $display("CHECK FAILED restart expected 1 seen 0");
      close_out();
    end
  endtask : wait_restart

  // wait entry, wake from mask m, expected vector e
  task automatic wait_wake(input logic [15:0] m, input logic [15:0] e, input int dly);
    strobe(1'b0);
    chk("wait_clocks", 16'h00FB, {7'h00, st});
    chk("wait_mask", 16'h0000, {15'h0000, imask_o});
    chk("unit_modes", 16'hFF00, {wait_active_o, stop_active_o});
    exp_q.push_back(e);
    u_src.raise(m, dly);
    wait_restart(n);
    chk("wait_latency", 16'h0002, 16'(n));
  endtask : wait_wake

  // oldest expected vector is taken at every restart pulse
  always @(posedge clk_sys_i) begin
    if (resetn_i === 1'b1 && cpu_restart_o === 1'b1) begin
      v = (exp_q.size() > 0) ? exp_q.pop_front() : 16'h0000;
      chk("vector_hi", v, vector_hi_addr_o);
      chk("vector_lo", v | 16'h0001, vector_lo_addr_o);
    end
  end

  // main sequence
  initial begin
    {clk_sys_i, resetn_i, wait_exec_i, stop_exec_i, pll_ctl_wr_i, break_irq_i} = 6'h00;
    {osc_run_in_stop_en_i, reset_req_i, clock_source_select_wdata_i} = 3'h0;
    pll_power_enable_wdata_i = 1'b0;
    {cpu_sei_i, cpu_cli_i, brk_flag_clr_i} = 3'h0;
    brk_en_i = 1'b1;
    converter_channel_select_i = 5'h00;
    irq_en_i = 16'hFFFF;
    repeat (8) @(posedge clk_sys_i);
    chk("reset_vector", 16'hFFFE, vector_hi_addr_o);
    chk("reset_regs", 16'h0004, {13'h0000, imask_o, clock_source_select_o, pll_power_enable_o});
    resetn_i <= 1'b1;
    #1;
    chk("run_clocks", 16'h01FB, {7'h00, st});
    // every source but the reserved slot alone, slow and prompt answers, back to back
    for (int i = 0; i < 16; i++) begin
      if (i != 9) begin
        wait_wake(16'h0001 << i, 16'hFFDC + 16'(2 * i), i % 3);
        chk("irq_exit_mask", 16'h0000, {15'h0000, imask_o});
      end
    end
    // mask set and clear while running, set wins when both pulse
    ctl_pulse(3'h6);
    chk("sei_mask", 16'h0001, {15'h0000, imask_o});
    ctl_pulse(3'h2);
    chk("cli_mask", 16'h0000, {15'h0000, imask_o});
    // random request and enable sets, highest enabled index wins
    for (int r = 0; r < 8; r++) begin
      rnd = lfsr(lfsr(rnd));
      irq_en_i <= rnd[31:16] | 16'h0004;
      n = 2;
      for (int k = 0; k < 16; k++) begin
        if (k != 9 && rnd[k] && (rnd[16 + k] || k == 2)) n = k;
      end
      wait_wake(rnd[15:0] | 16'h0004, 16'hFFDC + 16'(2 * n), 0);
    end
    irq_en_i <= 16'hFFFF;
    // powered-down converter and the reserved slot never wake
    converter_channel_select_i <= 5'h1F;
    strobe(1'b0);
    u_src.raise(16'h0202, 0);
    repeat (10) @(posedge clk_sys_i);
    chk("no_wake", 16'h0001, {15'h0000, in_wait_o});
    exp_q.push_back(16'hFFFA);
    u_src.raise(16'h8000, 0);
    wait_restart(n);
    converter_channel_select_i <= 5'h00;
    // stop with the oscillator off, pll selected beforehand
    @(posedge clk_sys_i);
    {pll_ctl_wr_i, clock_source_select_wdata_i, pll_power_enable_wdata_i} <= 3'h7;
    @(posedge clk_sys_i);
    pll_ctl_wr_i <= 1'b0;
    strobe(1'b1);
    chk("stop_clocks", 16'h0000, {7'h00, st});
    chk("stop_abort", 16'h0001, {15'h0000, adc_abort_o});
    chk("stop_regs", 16'h0000, {14'h0000, imask_o, clock_source_select_o});
    chk("unit_modes", 16'h0000, {wait_active_o, stop_active_o});
    strobe(1'b0);
    u_src.raise(16'h0002, 0);
    repeat (10) @(posedge clk_sys_i);
    chk("still_stop", 16'h0001, {in_wait_o, in_stop_o});
    exp_q.push_back(16'hFFFA);
    u_src.raise(16'h8000, 0);
    wait_restart(n);
    chk("stop_latency", 16'(STAB + 2), 16'(n));
    chk("stop_exit", 16'h0000, {15'h0000, imask_o | clock_source_select_o});
    // stop with the oscillator kept, break wakes
    osc_run_in_stop_en_i <= 1'b1;
    strobe(1'b1);
    chk("stop_osc", 16'h00F0, {7'h00, st});
    exp_q.push_back(16'hFFFC);
    @(posedge clk_sys_i);
    break_irq_i <= 1'b1;
    wait_restart(n);
    break_irq_i <= 1'b0;
    chk("break_latency", 16'(STAB + 1), 16'(n));
    chk("break_flag", 16'h0001, {15'h0000, break_during_wait_flag_o});
    ctl_pulse(3'h1);
    chk("break_flag_clr", 16'h0000, {15'h0000, break_during_wait_flag_o});
    // reset ends wait and sets the mask
    strobe(1'b0);
    exp_q.push_back(16'hFFFE);
    reset_req_i <= 1'b1;
    wait_restart(n);
    reset_req_i <= 1'b0;
    chk("reset_exit_mask", 16'h0001, {15'h0000, imask_o});
    brk_en_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk("brk_off", 16'h0000, {15'h0000, brk_active_o});
    chk("pending", 16'h0000, 16'(exp_q.size()));
    close_out();
  end
endmodule : low_power_mode_control_tb_top
